// ### core/vfs_pkg.sv
// Package: constants and carriers for the video format front end.
// Assumes a single core clock at the crystal rate.
package vfs_pkg;
    // Register offsets
    localparam logic [7:0]  ADDR_INPUT_FORMAT_SELECT   = 8'h01;
    localparam logic [7:0]  ADDR_HSC_LO  = 8'h08;
    localparam logic [7:0]  ADDR_HSC_HI  = 8'h09;
    localparam logic [7:0]  ADDR_GGD     = 8'h18;
    localparam logic [7:0]  ADDR_BGD     = 8'h19;
    // Field positions of input_format_select
    localparam int          XT_HI        = 4;
    localparam int          XT_LO        = 3;
    localparam int          FMT_HI       = 2;
    // Standard codes
    localparam logic [2:0]  STD_NTSC_M   = 3'h1;
    localparam logic [2:0]  STD_NTSC_J   = 3'h2;
    localparam logic [2:0]  STD_PAL_BI   = 3'h3;
    localparam logic [2:0]  STD_PAL_M    = 3'h4;
    localparam logic [2:0]  STD_PAL_N    = 3'h5;
    localparam logic [2:0]  STD_SECAM    = 3'h6;
    localparam logic [2:0]  STD_PAL_NC   = 3'h7;
    localparam logic [1:0]  XTAL_NTSC    = 2'h1;
    localparam logic [1:0]  XTAL_PAL     = 2'h2;
    // Reset values
    localparam logic [7:0]  INPUT_FORMAT_SELECT_RST    = 8'h09;
    localparam logic [15:0] HSC_RST      = 16'h02AA;
    localparam logic [7:0]  GGD_RST      = 8'h68;
    localparam logic [7:0]  BGD_RST      = 8'h5D;
    // Pixels per line at pixel rate
    localparam logic [10:0] LINE_525     = 11'h38E;
    localparam logic [10:0] LINE_625     = 11'h46F;
    // Black pedestal offset removed for NTSC-M
    localparam logic [7:0]  SETUP_OFS    = 8'h13;
    // Scaling steps in 1/4096 units
    localparam logic [16:0] HSC_UNITY    = 17'h01000;
    localparam logic [16:0] HSC_MAX_STEP = 17'h10000;
    localparam logic [3:0]  VDEC_FRM_MAX = 4'hF;
    localparam logic [3:0]  VDEC_FLD_MAX = 4'h7;
    // Last crystal clock count of each pixel (two cycles per pixel)
    localparam logic        PIX_DIV_LAST = 1'h1;

    typedef struct packed {
        logic       svideo;
        logic       mono;
        logic       prefilt;
        logic       comb;
        logic       field_mode;
    } vfs_mode_t;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] ca;
        logic [7:0] cb;
    } vfs_pix_t;
endpackage : vfs_pkg

// ### core/vfs_front.sv
// Video format select, Y/C separation, demodulation and data reduction.
// Assumes sample inputs and sync pulses are on core_clk_i.
`timescale 1ns/100ps

// Functional notes
// - Standard field codes: 001 NTSC-M through 111 PAL-N combination.
// - Crystal select 01 for 3.58 MHz-family standards, 10 for the rest.
// - 525 lines / 60 fields for NTSC and PAL-M; 625 / 50 otherwise.
// - NTSC-Japan has no setup pedestal; NTSC-M pedestal is removed.
// - Composite: chroma by bandpass, luma by notch filter.
// - Demodulator gives I/Q for NTSC, U/V for PAL and SECAM.
// - Optional chroma comb after demodulation using a line store.
// - S-Video luma skips separation; chroma goes straight to demodulator.
// - Monochrome bypasses separation; chroma and both demodulator outputs are forced to zero.
// - Scaling, cropping and temporal decimation act independently.
// - Independent horizontal and vertical reduction up to 16:1, vertical up to 8:1 in field mode.
// - Optional luma low-pass before horizontal scaling.
// - Unit delays: one pixel horizontally, one line vertically.
// - Pixel rate is the crystal clock halved.
module vfs_front (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    // Register port
    input  wire logic              reg_wr_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    output logic      [7:0]        reg_rdata_o,
    // Video samples and sync
    input  wire logic [7:0]        comp_i,
    input  wire logic [7:0]        svid_c_i,
    input  wire logic              line_start_i,
    input  wire logic              field_start_i,
    input  wire vfs_pkg::vfs_mode_t mode_i,
    // Reduction controls
    input  wire logic [10:0]       crop_hstart_i,
    input  wire logic [10:0]       crop_hcount_i,
    input  wire logic [3:0]        vdec_i,
    input  wire logic [3:0]        tdec_i,
    // Outputs
    output vfs_pkg::vfs_pix_t      pix_o,
    output logic                   pix_valid_o,
    output logic                   pix_rate_en_o,
    output logic                   is_625_o,
    output logic                   chroma_uv_o,
    output logic [1:0]             crystal_select_o,
    output logic [7:0]             gain_gate_delay_o,
    output logic [7:0]             burst_gate_delay_o
);
    import vfs_pkg::*;

    function automatic logic std_625(input logic [2:0] f);
        std_625 = !(f == STD_NTSC_M || f == STD_NTSC_J || f == STD_PAL_M);
    endfunction : std_625

    function automatic logic [7:0] avg_s(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {a[7], a} + {b[7], b};
        avg_s = s[8:1];
    endfunction : avg_s

    // Registers
    logic [7:0]  input_format_select_r, input_format_select_nxt, ggd_r, ggd_nxt, bgd_r, bgd_nxt, rdata_nxt;
    logic [15:0] hsc_r, hsc_nxt;
    logic [2:0]  fmt;
    assign fmt = input_format_select_r[FMT_HI:0];

    always_comb begin
        input_format_select_nxt = input_format_select_r;
        hsc_nxt   = hsc_r;
        ggd_nxt   = ggd_r;
        bgd_nxt   = bgd_r;
        rdata_nxt = 8'h00;
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_INPUT_FORMAT_SELECT:  input_format_select_nxt = {3'h0, reg_wdata_i[XT_HI:0]};
                ADDR_HSC_LO: hsc_nxt[7:0] = reg_wdata_i;
                ADDR_HSC_HI: hsc_nxt[15:8] = reg_wdata_i;
                ADDR_GGD:    ggd_nxt = reg_wdata_i;
                ADDR_BGD:    bgd_nxt = reg_wdata_i;
                default:     ;
            endcase
        end
        case (reg_addr_i)
            ADDR_INPUT_FORMAT_SELECT:  rdata_nxt = input_format_select_r;
            ADDR_HSC_LO: rdata_nxt = hsc_r[7:0];
            ADDR_HSC_HI: rdata_nxt = hsc_r[15:8];
            ADDR_GGD:    rdata_nxt = ggd_r;
            ADDR_BGD:    rdata_nxt = bgd_r;
            default:     rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            input_format_select_r     <= INPUT_FORMAT_SELECT_RST;
            hsc_r       <= HSC_RST;
            ggd_r       <= GGD_RST;
            bgd_r       <= BGD_RST;
            reg_rdata_o <= 8'h00;
        end else begin
            input_format_select_r     <= input_format_select_nxt;
            hsc_r       <= hsc_nxt;
            ggd_r       <= ggd_nxt;
            bgd_r       <= bgd_nxt;
            reg_rdata_o <= rdata_nxt;
        end
    end

    // Front-end pipeline at pixel rate
    logic        pix_en_r, pix_en_nxt;
    logic [7:0]  x0_r, x1_r, x2_r, x0_nxt;
    logic [7:0]  luma_r, luma_nxt, lprev_r, c_r, c_nxt;
    logic [7:0]  ca_r, cb_r, ca_nxt, cb_nxt;
    logic [1:0]  phase_r, phase_nxt;
    logic [10:0] hpos_r, hpos_nxt, line_len;
    logic [15:0] line_mem [0:1134];
    logic [15:0] mem_q;
    logic [8:0]  notch, lpf;
    logic [7:0]  bpass, luma_set;

    assign line_len = std_625(fmt) ? LINE_625 : LINE_525;
    assign mem_q    = line_mem[hpos_r];

    always_comb begin
        pix_en_nxt = !pix_en_r;
        x0_nxt     = comp_i;
        notch      = {1'b0, x0_r} + {1'b0, x2_r};
        bpass      = avg_s(x0_r, 8'(-x2_r));
        luma_nxt   = luma_r;
        c_nxt      = c_r;
        ca_nxt     = ca_r;
        cb_nxt     = cb_r;
        phase_nxt  = phase_r;
        hpos_nxt   = hpos_r;
        if (pix_en_r) begin
            phase_nxt = phase_r + 2'h1;
            hpos_nxt  = (hpos_r == line_len - 11'h1) ? 11'h000 : hpos_r + 11'h001;
            if (mode_i.mono) begin
                luma_nxt = x0_r;
                c_nxt    = 8'h00;
            end else if (mode_i.svideo) begin
                luma_nxt = x0_r;
                c_nxt    = svid_c_i;
            end else begin
                luma_nxt = notch[8:1];
                c_nxt    = bpass;
            end
            // Quadrature demodulation at four samples per subcarrier cycle
            case (phase_r)
                2'h0:    ca_nxt = c_r;
                2'h1:    cb_nxt = c_r;
                2'h2:    ca_nxt = 8'(-c_r);
                2'h3:    cb_nxt = 8'(-c_r);
                default: ca_nxt = c_r;
            endcase
            if (mode_i.mono) begin
                ca_nxt = 8'h00;
                cb_nxt = 8'h00;
            end
        end
        if (line_start_i) begin
            hpos_nxt  = 11'h000;
            phase_nxt = 2'h0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pix_en_r <= 1'b0;
            x0_r     <= 8'h00;
            x1_r     <= 8'h00;
            x2_r     <= 8'h00;
            luma_r   <= 8'h00;
            lprev_r  <= 8'h00;
            c_r      <= 8'h00;
            ca_r     <= 8'h00;
            cb_r     <= 8'h00;
            phase_r  <= 2'h0;
            hpos_r   <= 11'h000;
        end else begin
            pix_en_r <= pix_en_nxt;
            phase_r  <= phase_nxt;
            hpos_r   <= hpos_nxt;
            luma_r   <= luma_nxt;
            c_r      <= c_nxt;
            ca_r     <= ca_nxt;
            cb_r     <= cb_nxt;
            if (pix_en_r) begin
                x0_r    <= x0_nxt;
                x1_r    <= x0_r;
                x2_r    <= x1_r;
                lprev_r <= luma_r;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (pix_en_r) line_mem[hpos_r] <= {ca_r, cb_r};
    end

    // Pedestal, pre-filter and comb
    vfs_pix_t stage;
    always_comb begin
        luma_set = luma_r;
        if (fmt == STD_NTSC_M)
            luma_set = (luma_r > SETUP_OFS) ? luma_r - SETUP_OFS : 8'h00;
        lpf            = {1'b0, luma_set} + {1'b0, lprev_r};
        stage.luma     = mode_i.prefilt ? lpf[8:1] : luma_set;
        stage.ca       = mode_i.comb ? avg_s(ca_r, mem_q[15:8]) : ca_r;
        stage.cb       = mode_i.comb ? avg_s(cb_r, mem_q[7:0]) : cb_r;
    end

    // Data reduction
    typedef enum logic [1:0] {
        VFS_PASS = 2'b01,
        VFS_SKIP = 2'b10
    } vfs_fst_t;
    vfs_fst_t    fst_r, fst_nxt;
    logic [3:0]  fcnt_r, fcnt_nxt, vcnt_r, vcnt_nxt, vlim;
    logic [16:0] hacc_r, hacc_nxt, hstep, hsum;
    logic [17:0] hraw;
    logic [11:0] cend;
    logic        in_crop, keep, valid_nxt;

    always_comb begin
        hraw     = {2'b00, hsc_r} + {1'b0, HSC_UNITY};
        hstep    = (hraw > {1'b0, HSC_MAX_STEP}) ? HSC_MAX_STEP : hraw[16:0];
        vlim     = vdec_i;
        if (mode_i.field_mode && vdec_i > VDEC_FLD_MAX) vlim = VDEC_FLD_MAX;
        cend     = {1'b0, crop_hstart_i} + {1'b0, crop_hcount_i};
        in_crop  = hpos_r >= crop_hstart_i && {1'b0, hpos_r} < cend;
        hsum     = hacc_r + HSC_UNITY;
        hacc_nxt = hacc_r;
        keep     = 1'b0;
        if (pix_en_r && in_crop) begin
            keep     = hsum >= hstep;
            hacc_nxt = keep ? hsum - hstep : hsum;
        end
        valid_nxt = pix_en_r && keep && vcnt_r == 4'h0 && fst_r == VFS_PASS;
        vcnt_nxt  = vcnt_r;
        fcnt_nxt  = fcnt_r;
        fst_nxt   = fst_r;
        if (line_start_i) begin
            hacc_nxt = 17'h00000;
            vcnt_nxt = (vcnt_r >= vlim) ? 4'h0 : vcnt_r + 4'h1;
        end
        if (field_start_i) begin
            vcnt_nxt = 4'h0;
            fcnt_nxt = (fcnt_r >= tdec_i) ? 4'h0 : fcnt_r + 4'h1;
            case (fst_r)
                VFS_PASS: fst_nxt = (tdec_i == 4'h0) ? VFS_PASS : VFS_SKIP;
                VFS_SKIP: fst_nxt = (fcnt_r >= tdec_i) ? VFS_PASS : VFS_SKIP;
                default:  fst_nxt = VFS_PASS;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            fst_r              <= VFS_PASS;
            fcnt_r             <= 4'h0;
            vcnt_r             <= 4'h0;
            hacc_r             <= 17'h00000;
            pix_o              <= '0;
            pix_valid_o        <= 1'b0;
            pix_rate_en_o      <= 1'b0;
            is_625_o           <= 1'b0;
            chroma_uv_o        <= 1'b0;
            crystal_select_o   <= XTAL_NTSC;
            gain_gate_delay_o  <= GGD_RST;
            burst_gate_delay_o <= BGD_RST;
        end else begin
            fst_r              <= fst_nxt;
            fcnt_r             <= fcnt_nxt;
            vcnt_r             <= vcnt_nxt;
            hacc_r             <= hacc_nxt;
            pix_valid_o        <= valid_nxt;
            if (valid_nxt) pix_o <= stage;
            pix_rate_en_o      <= pix_en_r;
            is_625_o           <= std_625(fmt);
            chroma_uv_o        <= !(fmt == STD_NTSC_M || fmt == STD_NTSC_J);
            crystal_select_o   <= input_format_select_r[XT_HI:XT_LO];
            gain_gate_delay_o  <= ggd_r;
            burst_gate_delay_o <= bgd_r;
        end
    end

    // Checks
    default clocking cb_clk @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    pix_rate_a: assert property (pix_en_r |=> !pix_en_r ##1 pix_en_r)
        else $error("pixel enable not every second cycle");
    fmt_store_a: assert property (reg_wr_i && reg_addr_i == ADDR_INPUT_FORMAT_SELECT |=>
        fmt == $past(reg_wdata_i[2:0])) else $error("format field not stored");
    xtal_out_a: assert property (reg_wr_i && reg_addr_i == ADDR_INPUT_FORMAT_SELECT ##1 !reg_wr_i
        |=> crystal_select_o == $past(reg_wdata_i[4:3], 2)) else $error("crystal select wrong");
    lines_625_a: assert property (##1 is_625_o == std_625($past(fmt)))
        else $error("line structure flag wrong");
    uv_mode_a: assert property (fmt == STD_NTSC_J && $stable(fmt) |=> !chroma_uv_o)
        else $error("NTSC must give I/Q");
    setup_a: assert property (fmt == STD_NTSC_J |-> stage.luma == luma_r || mode_i.prefilt)
        else $error("pedestal removed for NTSC-Japan");
    mono_a: assert property (pix_en_r && mode_i.mono |=> c_r == 8'h00 && ca_r == 8'h00)
        else $error("mono chroma not zero");
    svid_a: assert property (pix_en_r && mode_i.svideo && !mode_i.mono |=>
        c_r == $past(svid_c_i) && luma_r == $past(x0_r)) else $error("svideo path wrong");
    hstep_a: assert property (hstep <= HSC_MAX_STEP && hstep >= HSC_UNITY)
        else $error("horizontal step out of range");
    vfield_a: assert property (mode_i.field_mode |-> vlim <= VDEC_FLD_MAX)
        else $error("field vertical reduction above 8:1");
    skip_a: assert property (fst_r == VFS_SKIP |=> !pix_valid_o)
        else $error("output during skipped field");

    svid_c: cover property (mode_i.svideo && pix_valid_o);
    comb_c: cover property (mode_i.comb && pix_valid_o);
    skip_c: cover property (fst_r == VFS_SKIP ##1 fst_r == VFS_PASS);
endmodule : vfs_front

// ### bench/vfs_src.sv
// Model of the analog source: digitized samples and sync pulses.
// Assumes the bench clock; everything changes at the falling edge.
`timescale 1ns/100ps
module vfs_src (
    // Clock
    input  wire logic       clk_i,
    // Samples and sync
    output logic      [7:0] comp_o,
    output logic      [7:0] chroma_o,
    output logic            line_start_o,
    output logic            field_start_o
);
    initial begin
        comp_o        = 8'h80;
        chroma_o      = 8'h00;
        line_start_o  = 1'b0;
        field_start_o = 1'b0;
    end

    // One line of npix pixels plus 12 pixels of margin, two clocks each; flat gives a constant level
    task automatic send_line(input int npix, input bit new_field, input bit flat);
        int i;
        if (new_field) begin
            @(negedge clk_i);
            field_start_o = 1'b1;
            @(negedge clk_i);
            field_start_o = 1'b0;
        end
        @(negedge clk_i);
        line_start_o = 1'b1;
        @(negedge clk_i);
        line_start_o = 1'b0;
        for (i = 0; i < npix * 2 + 24; i++) begin
            comp_o   = flat ? 8'h80 : (i[1] ? 8'hA0 : 8'h60);
            chroma_o = i[1] ? 8'h20 : 8'hE0;
            @(negedge clk_i);
        end
    endtask : send_line
endmodule : vfs_src

// ### bench/tb.sv
// Self-checking bench: register port, standards table, video reduction.
// Assumes the source model drives the video inputs.
`timescale 1ns/100ps
module tb;
    import vfs_pkg::*;
    logic              core_clk_i, sys_rst_i, reg_wr_i;
    logic [7:0]        reg_addr_i, reg_wdata_i, reg_rdata_o, comp_i, svid_c_i;
    logic              line_start_i, field_start_i, pix_valid_o, pix_rate_en_o;
    logic              is_625_o, chroma_uv_o;
    vfs_mode_t         mode_i;
    logic [10:0]       crop_hstart_i, crop_hcount_i;
    logic [3:0]        vdec_i, tdec_i;
    vfs_pix_t          pix_o;
    logic [1:0]        crystal_select_o;
    logic [7:0]        gain_gate_delay_o, burst_gate_delay_o, luma_m;
    logic [7:0]        luma_last = 8'h00;
    logic              en_prev;
    int                n_fail, checked, base, k;
    int                n_pix = 0;
    logic [2:0]        code [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [1:0]        xt   [7] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h1};
    logic [15:0]       hsc  [7] = '{16'h02AA, 16'h02AA, 16'h033C, 16'h02AC,
                                    16'h033C, 16'h033C, 16'h00F8};
    logic [7:0]        gg   [7] = '{8'h68, 8'h68, 8'h7F, 8'h68, 8'h7F, 8'h7F, 8'h7F};
    logic [7:0]        bg   [7] = '{8'h5D, 8'h5D, 8'h72, 8'h5D, 8'h72, 8'hA0, 8'h72};
    logic              l625 [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic              uv   [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [7:0]        ra   [6] = '{8'h01, 8'h08, 8'h09, 8'h18, 8'h19, 8'h02};
    logic [7:0]        rv   [6] = '{8'h09, 8'hAA, 8'h02, 8'h68, 8'h5D, 8'h00};

    vfs_front vfs_front_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .comp_i(comp_i), .svid_c_i(svid_c_i),
        .line_start_i(line_start_i), .field_start_i(field_start_i), .mode_i(mode_i),
        .crop_hstart_i(crop_hstart_i), .crop_hcount_i(crop_hcount_i), .vdec_i(vdec_i),
        .tdec_i(tdec_i), .pix_o(pix_o), .pix_valid_o(pix_valid_o),
        .pix_rate_en_o(pix_rate_en_o), .is_625_o(is_625_o), .chroma_uv_o(chroma_uv_o),
        .crystal_select_o(crystal_select_o), .gain_gate_delay_o(gain_gate_delay_o),
        .burst_gate_delay_o(burst_gate_delay_o));
    vfs_src vfs_src_inst (.clk_i(core_clk_i), .comp_o(comp_i), .chroma_o(svid_c_i),
        .line_start_o(line_start_i), .field_start_o(field_start_i));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (pix_valid_o === 1'b1) begin
            n_pix     <= n_pix + 1;
            luma_last <= pix_o.luma;
        end
    end

    task automatic results;
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_wr_i    = 1'b1;
        reg_addr_i  = a;
        reg_wdata_i = d;
        @(negedge core_clk_i);
        reg_wr_i    = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk_i);
        reg_addr_i = a;
        repeat (2) @(negedge core_clk_i);
        chk({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : rd

    // Lines of 40 pixels, crop 8..23, counting output pixels
    task automatic run(input int nl, input bit nf, input logic [15:0] exp);
        int i;
        base = n_pix;
        for (i = 0; i < nl; i++)
            vfs_src_inst.send_line(40, nf && i == 0, 1'b0);
        chk(16'(n_pix - base), exp);
    endtask : run

    initial begin
        #200000;
        n_fail++;
        results();
    end

    initial begin
        n_fail = 0; checked = 0;
        sys_rst_i = 1'b1; reg_wr_i = 1'b0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
        mode_i = '0; crop_hstart_i = 11'h008; crop_hcount_i = 11'h010;
        vdec_i = 4'h0; tdec_i = 4'h0;
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        for (k = 0; k < 6; k++) rd(ra[k], rv[k]);
        chk({6'h0, crystal_select_o, gain_gate_delay_o}, {6'h0, XTAL_NTSC, GGD_RST});
        chk({8'h00, burst_gate_delay_o}, {8'h00, BGD_RST});
        for (k = 0; k < 4; k++) begin
            en_prev = pix_rate_en_o;
            @(negedge core_clk_i);
            chk({15'h0, pix_rate_en_o ^ en_prev}, 16'h0001);
        end
        for (k = 0; k < 7; k++) begin
            wr(ADDR_INPUT_FORMAT_SELECT, {3'b111, xt[k], code[k]});
            wr(ADDR_HSC_LO, hsc[k][7:0]);
            wr(ADDR_HSC_HI, hsc[k][15:8]);
            wr(ADDR_GGD, gg[k]);
            wr(ADDR_BGD, bg[k]);
            rd(ADDR_INPUT_FORMAT_SELECT, {3'b000, xt[k], code[k]});
            rd(ADDR_HSC_HI, hsc[k][15:8]);
            chk({6'h0, crystal_select_o, gain_gate_delay_o}, {6'h0, xt[k], gg[k]});
            chk({burst_gate_delay_o, 6'h0, is_625_o, chroma_uv_o},
                {bg[k], 6'h0, l625[k], uv[k]});
        end
        wr(ADDR_HSC_LO, 8'h00);
        wr(ADDR_HSC_HI, 8'h00);
        wr(ADDR_INPUT_FORMAT_SELECT, {3'b000, XTAL_NTSC, STD_NTSC_M});
        mode_i.mono = 1'b1;
        vfs_src_inst.send_line(40, 1'b1, 1'b1);
        luma_m = luma_last;
        chk({pix_o.ca, pix_o.cb}, 16'h0000);
        wr(ADDR_INPUT_FORMAT_SELECT, {3'b000, XTAL_NTSC, STD_NTSC_J});
        vfs_src_inst.send_line(40, 1'b1, 1'b1);
        chk({8'h00, luma_last - luma_m}, {8'h00, SETUP_OFS});
        for (k = 0; k < 5; k++) begin
            mode_i = vfs_mode_t'(5'(k == 0 ? 0 : 1 << k));
            run(1, 1'b1, 16'h0010);
        end
        mode_i = '0;
        vdec_i = 4'h1;
        run(4, 1'b1, 16'h0020);
        vdec_i = 4'h0;
        tdec_i = 4'h1;
        run(1, 1'b1, 16'h0000);
        run(1, 1'b1, 16'h0010);
        tdec_i = 4'h0;
        mode_i.field_mode = 1'b1;
        vdec_i = 4'hF;
        run(8, 1'b1, 16'h0010);
        results();
    end
endmodule : tb
